// ==== design/tc_timer.sv ====
/*
  Sixteen-bit timer/counter with APB register access and overflow interrupt.
  Assumes ext_clock_pin and sysclk_from_timer_osc_in are synchronous to sys_clk;
  sys_clk is the oscillator clock, internal count clock is a quarter of it.
*/
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "tc_regs.svh"

module tc_timer #(
  parameter int INT_DIV = 4
) (
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [`TC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 ext_clock_pin,
  input  wire logic                 sysclk_from_timer_osc_in,
  output logic                      timer_osc_enable,
  output logic                      irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tc_pkg::tc_ctrl_t ctrl;
  logic [15:0]      count;
  logic [7:0]       high_rd_buf;
  logic [7:0]       high_wr_buf;
  logic             irq_status;
  logic             irq_mask;
  logic [1:0]       int_cnt;
  logic             pin_s1;
  logic             pin_s2;
  logic             pin_s3;
  logic             pin_raw_prev;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [`TC_ADDR_W-1:0] a,
                               input logic [`TC_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  wire setup    = psel && !penable;
  wire access   = psel && penable;
  wire sel_ctrl = hit(paddr, `TC_OFF_CTRL);
  wire sel_lo   = hit(paddr, `TC_OFF_CNT_LO);
  wire sel_hi   = hit(paddr, `TC_OFF_CNT_HI);
  wire sel_st   = hit(paddr, `TC_OFF_IRQ_ST);
  wire sel_msk  = hit(paddr, `TC_OFF_IRQ_MSK);
  wire mapped   = sel_ctrl | sel_lo | sel_hi | sel_st | sel_msk;
  wire wr       = access && pwrite && mapped;
  wire wr_ctrl  = wr && sel_ctrl;
  wire wr_lo    = wr && sel_lo;
  wire wr_hi    = wr && sel_hi;
  wire wr_st    = wr && sel_st;
  wire wr_msk   = wr && sel_msk;
  wire rd_lo    = setup && !pwrite && sel_lo;

  // zero wait states; answer comes in the access cycle
  assign pready  = access;
  assign pslverr = access && !mapped;

  // ----------------------------------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------------------------------
  // status bit 6 always reflects the live clock-source indication
  wire [7:0] ctrl_rd = {ctrl.wide_access_mode, sysclk_from_timer_osc_in,
                        ctrl.prescale_select, ctrl.timer_osc_enable,
                        ctrl.ext_sync_select_n, ctrl.clock_source_select,
                        ctrl.counter_on};
  // wide mode returns the byte frozen at the last low read
  wire [7:0] hi_rd   = ctrl.wide_access_mode ? high_rd_buf : count[15:8];
  wire [7:0] rd_byte = sel_ctrl ? ctrl_rd :
                       sel_lo   ? count[7:0] :
                       sel_hi   ? hi_rd :
                       sel_st   ? {7'h00, irq_status} :
                       sel_msk  ? {7'h00, irq_mask} : 8'h00;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      prdata <= {24'h000000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // bit 6 is read-only, so its storage stays zero
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= `TC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= pwdata[7:0] & `TC_CTRL_WMASK;
    end
  end

  assign timer_osc_enable = ctrl.timer_osc_enable;

  // ----------------------------------------------------------------
  // clock sources
  // ----------------------------------------------------------------
  // internal clock: one tick every INT_DIV oscillator cycles
  wire int_tick = (int_cnt == 2'(INT_DIV - 1));

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_cnt <= 2'h0;
    end else begin
      int_cnt <= int_tick ? 2'h0 : int_cnt + 2'h1;
    end
  end

  // two-stage synchroniser; s1 feeds only s2
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1       <= 1'b0;
      pin_s2       <= 1'b0;
      pin_s3       <= 1'b0;
      pin_raw_prev <= 1'b0;
    end else begin
      pin_s1       <= ext_clock_pin;
      pin_s2       <= pin_s1;
      pin_s3       <= pin_s2;
      pin_raw_prev <= ext_clock_pin;
    end
  end

  // rising edges; the raw path trades metastability margin for latency
  wire sync_edge = pin_s2 && !pin_s3;
  wire raw_edge  = ext_clock_pin && !pin_raw_prev;
  wire ext_edge  = ctrl.ext_sync_select_n ? raw_edge : sync_edge;
  // sync bit has no say on the internal source
  wire src_tick  = ctrl.clock_source_select ? ext_edge : int_tick;
  wire pre_in    = src_tick && ctrl.counter_on;
  wire cnt_tick;

  tc_prescale u_prescale (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .tick_in  (pre_in),
    .clear    (wr_lo || wr_hi),
    .ratio    (tc_pkg::tc_div_t'(ctrl.prescale_select)),
    .tick_out (cnt_tick)
  );

  // ----------------------------------------------------------------
  // counter and byte buffers
  // ----------------------------------------------------------------
  wire        wide     = ctrl.wide_access_mode;
  wire        overflow = cnt_tick && (count == `TC_CNT_MAX) && !wr_lo && !wr_hi;
  // low-byte writes and byte-mode high-byte writes win over a tick in the same cycle; a wide-mode high write does not
  wire [15:0] next_count = (wr_lo && wide)  ? {high_wr_buf, pwdata[7:0]} :
                           wr_lo            ? {count[15:8], pwdata[7:0]} :
                           (wr_hi && !wide) ? {pwdata[7:0], count[7:0]} :
                           cnt_tick         ? count + 16'h0001 : count;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= `TC_CNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  // high-byte buffers used only in wide mode
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      high_rd_buf <= 8'h00;
      high_wr_buf <= 8'h00;
    end else begin
      if (rd_lo && wide) begin
        high_rd_buf <= count[15:8];
      end
      if (wr_hi && wide) begin
        high_wr_buf <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  // a new overflow beats a write-one-to-clear in the same cycle
  wire next_status = overflow || (irq_status && !(wr_st && pwdata[`TC_IRQ_OVF]));

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_status <= `TC_IRQ_RESET;
      irq_mask   <= `TC_IRQ_RESET;
    end else begin
      irq_status <= next_status;
      if (wr_msk) begin
        irq_mask <= pwdata[`TC_IRQ_OVF];
      end
    end
  end

  assign irq = irq_status && irq_mask;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_OVF_SETS_FLAG: assert property (@(posedge sys_clk) disable iff (sys_rst)
    overflow |=> irq_status && count == 16'h0000)
    else $error("overflow did not wrap and flag");

  AST_OFF_HOLDS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!ctrl.counter_on && !wr_lo && !wr_hi) |=> count == $past(count))
    else $error("counter moved while off");

  AST_BYTE_LO_WRITE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_lo |=> count[7:0] == $past(pwdata[7:0]))
    else $error("low byte write lost");

  AST_BYTE_HI_WRITE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (wr_hi && !wide) |=> count[15:8] == $past(pwdata[7:0]))
    else $error("byte mode high write lost");

  AST_WIDE_HI_DEFER: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (wr_lo && wide) |=> count == {$past(high_wr_buf), $past(pwdata[7:0])})
    else $error("buffered high byte not applied");

  AST_WIDE_RD_LATCH: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (rd_lo && wide) |=> high_rd_buf == $past(count[15:8]))
    else $error("high byte not latched on low read");

  AST_RUN_STATUS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (setup && !pwrite && sel_ctrl) |=> prdata[`TC_BIT_RUN] == $past(sysclk_from_timer_osc_in))
    else $error("clock status bit wrong");

  AST_OSC_ENABLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_ctrl |=> timer_osc_enable == $past(pwdata[3]))
    else $error("oscillator enable not following write");

  AST_SYNC_PATH: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ctrl.clock_source_select && !ctrl.ext_sync_select_n && src_tick) |->
      $past(ext_clock_pin, 2) && !$past(ext_clock_pin, 3))
    else $error("synchronised edge not delayed");

  AST_INT_IGNORES_SYNC: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!ctrl.clock_source_select && src_tick) |=> !src_tick [*3])
    else $error("internal clock faster than a quarter");

  AST_EXT_EDGE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ctrl.clock_source_select && ctrl.ext_sync_select_n && src_tick) |-> ext_clock_pin && !$past(ext_clock_pin))
    else $error("external tick without rising edge");

  AST_DIV1_PASS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ctrl.prescale_select == 2'h0 && pre_in && !wr_lo && !wr_hi) |-> cnt_tick)
    else $error("divide-by-1 dropped a tick");

endmodule

// ==== common/tc_regs.svh ====
/*
  Register offsets, field positions and reset values of the 16-bit timer/counter.
  Assumes inclusion by bare name from design files; definitions only.
*/
// Contract
// - Sixteen-bit count held as high and low bytes, both read/write by software.
// - Overflow flag raised when count wraps from all ones to zero; a wide-mode high-byte write in the wrap cycle leaves it clear.
// - Count advances only while the on bit (bit 0) is set.
// - Wide mode bit 7 moves the count as one 16-bit unit, else two bytes.
// - Read-only bit 6 reports system clock taken from the timer oscillator.
// - Bits 5-4 choose the prescale ratio of the counter input clock.
// - Bit 3 enables the timer oscillator; clear shuts it off.
// - External source: bit 2 one passes pin unsynchronized, zero synchronizes it.
// - Internal source ignores the sync bit and counts the internal clock.
`ifndef TC_REGS_SVH
`define TC_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TC_ADDR_W      12
`define TC_OFF_CTRL    12'h000
`define TC_OFF_CNT_LO  12'h004
`define TC_OFF_CNT_HI  12'h008
`define TC_OFF_IRQ_ST  12'h00C
`define TC_OFF_IRQ_MSK 12'h010

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define TC_CTRL_RESET  8'h00
`define TC_CTRL_WMASK  8'hBF
`define TC_BIT_RUN     6
`define TC_CNT_RESET   16'h0000
`define TC_CNT_MAX     16'hFFFF
`define TC_IRQ_RESET   1'h0
`define TC_IRQ_OVF     0
`define TC_PRE_W       3

`endif

// ==== common/tc_pkg.sv ====
/*
  Types shared by the timer/counter files.
  Assumes the field layout of tc_regs.svh.
*/
package tc_pkg;

  // ----------------------------------------------------------------
  // control register layout, bit 7 down to bit 0
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wide_access_mode;
    logic       sysclk_from_timer_osc;
    logic [1:0] prescale_select;
    logic       timer_osc_enable;
    logic       ext_sync_select_n;
    logic       clock_source_select;
    logic       counter_on;
  } tc_ctrl_t;

  // ----------------------------------------------------------------
  // prescale ratio codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TC_DIV1,
    TC_DIV2,
    TC_DIV4,
    TC_DIV8
  } tc_div_t;

endpackage

// ==== design/tc_prescale.sv ====
/*
  Input prescaler: passes one of every 1, 2, 4 or 8 input ticks.
  Assumes tick_in is a one-cycle pulse in the sys_clk domain.
*/
`timescale 1ns/100ps
`include "tc_regs.svh"

module tc_prescale (
  input  wire logic           sys_clk,
  input  wire logic           sys_rst,
  input  wire logic           tick_in,
  input  wire logic           clear,
  input  wire tc_pkg::tc_div_t ratio,
  output logic                tick_out
);

  logic [`TC_PRE_W-1:0] pre_cnt;
  logic [`TC_PRE_W-1:0] ratio_mask;

  // ----------------------------------------------------------------
  // ratio decode
  // ----------------------------------------------------------------
  always_comb begin
    unique case (ratio)
      tc_pkg::TC_DIV1: ratio_mask = 3'h0;
      tc_pkg::TC_DIV2: ratio_mask = 3'h1;
      tc_pkg::TC_DIV4: ratio_mask = 3'h3;
      tc_pkg::TC_DIV8: ratio_mask = 3'h7;
    endcase
  end

  // pass the tick that completes the ratio
  assign tick_out = tick_in && ((pre_cnt & ratio_mask) == ratio_mask);

  // divider count; cleared on count writes so the ratio restarts cleanly
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_cnt <= 3'h0;
    end else if (clear) begin
      pre_cnt <= 3'h0;
    end else if (tick_in) begin
      pre_cnt <= pre_cnt + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_DIV8_SPACING: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ratio == tc_pkg::TC_DIV8 && tick_out && !clear) |=> pre_cnt == 3'h0 && (ratio != tc_pkg::TC_DIV8 || !tick_out))
    else $error("divide-by-8 tick out of step");

endmodule

// ==== test/tc_osc_model.sv ====
/*
  Far-side model: external count clock pin and timer oscillator status.
  Assumes the timer's sys_clk; pin edges are launched just after rising edges.
*/
`timescale 1ns/100ps

module tc_osc_model (
  input  wire logic       sys_clk,
  input  wire logic       timer_osc_enable,
  input  wire logic       osc_select,
  input  wire logic       go,
  input  wire logic [7:0] edges_req,
  output logic            ext_clock_pin,
  output logic            sysclk_from_timer_osc_in,
  output logic            busy
);
  logic [7:0] left;
  logic [1:0] ph;

  // ----------------------------------------------------------------
  // burst generator
  // ----------------------------------------------------------------
  initial begin
    ext_clock_pin = 1'b0;
    left = 8'h00;
    ph = 2'h0;
    busy = 1'b0;
  end

  // pin stands low between bursts; 3 cycles per phase suits the sync path
  always @(posedge sys_clk) begin
    if (go) begin
      left <= edges_req;
      busy <= 1'b1;
    end else if (left != 8'h00) begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      if (ph == 2'h2) begin
        ext_clock_pin <= ~ext_clock_pin; // rising edges are the counted unit
        if (ext_clock_pin) left <= left - 8'h01;
      end
    end else begin
      busy <= 1'b0;
    end
  end

  // oscillator can only feed the system clock while it is enabled
  assign sysclk_from_timer_osc_in = osc_select & timer_osc_enable;
endmodule

// ==== test/tb_tc_timer.sv ====
/*
  Self-checking bench of the timer/counter over APB.
  Assumes tc_osc_model on the pin side and zero-wait APB answers.
*/
`timescale 1ns/100ps
`include "tc_regs.svh"

module tb_tc_timer;
  logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, a;
  logic        ext_clock_pin, sys_in, osc_en, osc_select, go, busy, last_err;
  logic [7:0]  edges_req, v;
  logic [15:0] w;
  int          seed, bad_count, compares, n, e;

  // ----------------------------------------------------------------
  // structure
  // ----------------------------------------------------------------
  tc_timer #(.INT_DIV(4)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clock_pin(ext_clock_pin), .sysclk_from_timer_osc_in(sys_in), .timer_osc_enable(osc_en), .irq(irq));
  tc_osc_model osc (.sys_clk(sys_clk), .timer_osc_enable(osc_en), .osc_select(osc_select), .go(go),
    .edges_req(edges_req), .ext_clock_pin(ext_clock_pin), .sysclk_from_timer_osc_in(sys_in), .busy(busy));

  always #5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("TB: %0d errors in %0d checks", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      $display("Error %s expected %h seen %h", nm, ex, got);
      bad_count++;
    end
  endtask

  // one transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      bad_count++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [11:0] ad, input logic [7:0] d);
    apb(1'b1, ad, {24'h000000, d}, a);
  endtask

  task automatic rd(input string nm, input logic [11:0] ad, input logic [7:0] ex);
    apb(1'b0, ad, 32'h00000000, q);
    chk(nm, {24'h000000, ex}, q);
  endtask

  // expected internal ticks over a span with a prescale code
  function automatic int exp_ticks(input int span, input int code);
    return span / (4 << code);
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0; sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h00000000; osc_select = 1'b0; go = 1'b0; edges_req = 8'h00;
    seed = 95; bad_count = 0; compares = 0;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd("ctrl_rst", `TC_OFF_CTRL, 8'h00);
    rd("lo_rst", `TC_OFF_CNT_LO, 8'h00);
    rd("hi_rst", `TC_OFF_CNT_HI, 8'h00);
    rd("st_rst", `TC_OFF_IRQ_ST, 8'h00);
    rd("msk_rst", `TC_OFF_IRQ_MSK, 8'h00);
    rd("unmapped", 12'h020, 8'h00);
    chk("pslverr", 32'h1, {31'h0, last_err});
    // random control values, counter kept off; bit 6 follows the oscillator
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed)) & 8'hFE;
      osc_select <= i[0];
      wr(`TC_OFF_CTRL, v);
      rd("ctrl", `TC_OFF_CTRL, (v & 8'hBF) | {1'b0, i[0] & v[3], 6'h00});
      chk("osc_en", {31'h0, v[3]}, {31'h0, osc_en});
    end
    // byte mode: both halves independent
    wr(`TC_OFF_CTRL, 8'h00);
    w = 16'($random(seed));
    wr(`TC_OFF_CNT_LO, w[7:0]);
    wr(`TC_OFF_CNT_HI, w[15:8]);
    rd("lo", `TC_OFF_CNT_LO, w[7:0]);
    rd("hi", `TC_OFF_CNT_HI, w[15:8]);
    // wide mode: high write waits for low write, low read latches high
    wr(`TC_OFF_CTRL, 8'h80);
    wr(`TC_OFF_CNT_HI, 8'h12);
    wr(`TC_OFF_CTRL, 8'h00);
    rd("hi_buffered", `TC_OFF_CNT_HI, w[15:8]);
    wr(`TC_OFF_CTRL, 8'h80);
    wr(`TC_OFF_CNT_LO, 8'h34);
    wr(`TC_OFF_CTRL, 8'h00);
    rd("wide_lo", `TC_OFF_CNT_LO, 8'h34);
    rd("wide_hi", `TC_OFF_CNT_HI, 8'h12);
    wr(`TC_OFF_CTRL, 8'h80);
    rd("latch_lo", `TC_OFF_CNT_LO, 8'h34);
    wr(`TC_OFF_CTRL, 8'h00);
    wr(`TC_OFF_CNT_HI, 8'h00);
    wr(`TC_OFF_CTRL, 8'h80);
    rd("latch_hi", `TC_OFF_CNT_HI, 8'h12);
    // internal clock at every prescale code; sync bit set at random
    for (int c = 0; c < 4; c++) begin
      wr(`TC_OFF_CTRL, 8'h00);
      wr(`TC_OFF_CNT_LO, 8'h00);
      wr(`TC_OFF_CNT_HI, 8'h00);
      wr(`TC_OFF_CTRL, {2'b00, c[1:0], 1'b0, 1'($random(seed)), 2'b01});
      repeat (128) @(posedge sys_clk);
      apb(1'b0, `TC_OFF_CNT_LO, 32'h0, q);
      e = exp_ticks(128, c);
      chk("rate", 32'h1, {31'h0, q >= e && q <= e + 2});
    end
    // counting halts while the on bit is clear
    wr(`TC_OFF_CTRL, 8'h00);
    apb(1'b0, `TC_OFF_CNT_LO, 32'h0, a);
    repeat (40) @(posedge sys_clk);
    rd("halt", `TC_OFF_CNT_LO, a[7:0]);
    // external pin edges, synchronized and not
    for (int s = 0; s < 2; s++) begin
      wr(`TC_OFF_CTRL, 8'h00);
      wr(`TC_OFF_CNT_LO, 8'h00);
      wr(`TC_OFF_CTRL, {5'h00, s[0], 2'b11});
      edges_req <= 8'h05 + 8'($random(seed) & 7);
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      @(posedge sys_clk);
      n = 0;
      while (busy === 1'b1 && n < 300) begin
        @(posedge sys_clk);
        n++;
      end
      if (n >= 300) begin
        bad_count++;
        report_and_stop();
      end
      repeat (4) @(posedge sys_clk);
      rd("ext_edges", `TC_OFF_CNT_LO, edges_req);
    end
    // overflow from all ones sets the sticky flag; mask gates irq
    wr(`TC_OFF_CTRL, 8'h00);
    wr(`TC_OFF_CNT_LO, 8'hFF);
    wr(`TC_OFF_CNT_HI, 8'hFF);
    wr(`TC_OFF_IRQ_MSK, 8'h01);
    rd("st_pre", `TC_OFF_IRQ_ST, 8'h00);
    wr(`TC_OFF_CTRL, 8'h01);
    n = 0;
    while (irq !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 20) begin
      bad_count++;
      report_and_stop();
    end
    wr(`TC_OFF_CTRL, 8'h00);
    chk("irq_set", 32'h1, {31'h0, irq});
    rd("st_ovf", `TC_OFF_IRQ_ST, 8'h01);
    rd("hi_wrap", `TC_OFF_CNT_HI, 8'h00);
    wr(`TC_OFF_IRQ_MSK, 8'h00);
    // mask lands at the access edge; look one edge later once it has settled
    @(posedge sys_clk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(`TC_OFF_IRQ_MSK, 8'h01);
    wr(`TC_OFF_IRQ_ST, 8'h01);
    rd("st_clr", `TC_OFF_IRQ_ST, 8'h00);
    chk("irq_clr", 32'h0, {31'h0, irq});
    report_and_stop();
  end
endmodule
